// ---- src/sar_seq_pkg.sv ----
/*
 * Shared constants and carriers for the successive-approximation sequencer.
 * Assumes a single 20 MHz system clock and an analog front end driven by the
 * switch controls and read back through one comparator bit.
 */
package sar_seq_pkg;

    localparam int RESULT_WIDTH = 16;
    localparam int CLK_HZ = 20_000_000;
    localparam int RATE_SPS = 250_000;
    // Whole cycles per conversion slot at the top rate, rounded down
    localparam int SLOT_CYCLES = CLK_HZ / RATE_SPS;
    localparam int SETTLE_CYCLES = 2;
    localparam int BIT_CYCLES = 2;

    localparam logic [15:0] CODE_MAX = 16'h7FFF;
    localparam logic [15:0] CODE_MIN = 16'h8000;
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [4:0] BIT_TOP = 5'h0F;

    typedef enum logic [2:0]
    {
        ST_ACQUIRE = 3'b000,
        ST_OPEN_GROUND = 3'b001,
        ST_HOLD = 3'b011,
        ST_TRIAL = 3'b010,
        ST_DONE = 3'b110
    } seq_state_e;

    typedef struct packed
    {
        logic pos_array_ground_switch;
        logic neg_array_ground_switch;
        logic inputs_attached;
        logic arrays_grounded;
        logic powered;
    } front_ctrl_s;

    typedef struct packed
    {
        logic [15:0] code;
        logic chain_mode;
    } result_s;

endpackage

// ---- src/sar_conversion_sequencer.sv ----
/*
 * Conversion sequencer: sampling switch order, binary search over the
 * 16-element capacitor arrays, saturating two's-complement result.
 * Assumes convert_strobe and comparator are synchronous to sys_clk and
 * that the comparator settles within one trial step.
 */
`timescale 1ns/100ps

module sar_conversion_sequencer
#(
    parameter int WIDTH = sar_seq_pkg::RESULT_WIDTH
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Host strobe and mode selection
    input wire logic convert_strobe,
    input wire logic mode_select,
    // Analog front end
    input wire logic comparator,
    input wire logic over_range,
    input wire logic under_range,
    output sar_seq_pkg::front_ctrl_s front_ctrl,
    output logic [WIDTH-1:0] dac_pos,
    output logic [WIDTH-1:0] dac_neg,
    // Result
    output sar_seq_pkg::result_s result,
    output logic busy,
    output logic done_pulse
);
    import sar_seq_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // Bit index and trial logic are sized for exactly 16 elements
    if (WIDTH != RESULT_WIDTH)
    begin : g_width_check
        $error("WIDTH must equal the array element count");
    end

    // The 4-bit step counter cannot pace longer phases
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 16 || BIT_CYCLES < 1 || BIT_CYCLES > 16)
    begin : g_step_check
        $error("phase lengths must lie between 1 and 16 cycles");
    end

    // Open, hold, all trials and done must fit one slot at the top rate
    if (2 * SETTLE_CYCLES + RESULT_WIDTH * BIT_CYCLES + 1 > SLOT_CYCLES)
    begin : g_rate_check
        $error("conversion does not fit the sample slot");
    end

    function automatic logic is_idle(input seq_state_e s);
        return (s == ST_ACQUIRE);
    endfunction

    // ************************************************************
    // Sequencing
    // ************************************************************
    seq_state_e state_reg;
    seq_state_e state_next;
    logic strobe_prev_reg;
    logic [4:0] bit_reg;
    logic [3:0] step_reg;
    logic [WIDTH-1:0] trial_reg;
    logic [WIDTH-1:0] code_reg;
    logic chain_reg;
    logic done_reg;
    logic start;
    logic step_end;

    assign start = convert_strobe & ~strobe_prev_reg;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            strobe_prev_reg <= 1'b0;
        end
        else
        begin
            strobe_prev_reg <= convert_strobe;
        end
    end

    // One short step counter paces the open, hold and trial phases; no external clock used
    assign step_end = (step_reg == 4'(BIT_CYCLES - 1));

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_ACQUIRE:
            begin
                // Start only from acquisition: edges mid-conversion are lost
                if (start)
                begin
                    state_next = ST_OPEN_GROUND;
                end
            end
            ST_OPEN_GROUND:
            begin
                if (step_reg == 4'(SETTLE_CYCLES - 1))
                begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (step_reg == 4'(SETTLE_CYCLES - 1))
                begin
                    state_next = ST_TRIAL;
                end
            end
            ST_TRIAL:
            begin
                if (step_end && bit_reg == 5'h00)
                begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE:
            begin
                state_next = ST_ACQUIRE;
            end
            default:
            begin
                state_next = ST_ACQUIRE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_ACQUIRE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            step_reg <= 4'h0;
        end
        else if (state_next != state_reg || (state_reg == ST_TRIAL && step_end))
        begin
            step_reg <= 4'h0;
        end
        else if (!is_idle(state_reg))
        begin
            step_reg <= step_reg + 4'h1;
        end
    end

    // ************************************************************
    // Interface mode capture
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            chain_reg <= 1'b0;
        end
        else if (is_idle(state_reg) && start)
        begin
            chain_reg <= ~mode_select;
        end
    end

    // ************************************************************
    // Binary search
    // ************************************************************
    // Index of the element under trial, top element first
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bit_reg <= BIT_TOP;
        end
        else if (state_reg == ST_HOLD && state_next == ST_TRIAL)
        begin
            bit_reg <= BIT_TOP;
        end
        else if (state_reg == ST_TRIAL && step_end && bit_reg != 5'h00)
        begin
            bit_reg <= bit_reg - 5'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            trial_reg <= CODE_RESET;
        end
        else if (state_reg == ST_HOLD && state_next == ST_TRIAL)
        begin
            trial_reg <= CODE_MIN;
        end
        else if (state_reg == ST_TRIAL && step_end)
        begin
            // Offset-binary search; MSB weight first, then halves
            if (!comparator)
            begin
                trial_reg[bit_reg[3:0]] <= 1'b0;
            end
            if (bit_reg != 5'h00)
            begin
                trial_reg[bit_reg[3:0] - 4'h1] <= 1'b1;
            end
        end
    end

    // Both arrays carry the same trial word, mirrored in polarity
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_element
        assign dac_pos[i] = trial_reg[i];
        assign dac_neg[i] = ~trial_reg[i];
    end

    // ************************************************************
    // Result and completion
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= (state_reg == ST_DONE);
        end
    end

    // Range flags count only in the done cycle; over-range wins if both
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            code_reg <= CODE_RESET;
        end
        else if (state_reg == ST_DONE)
        begin
            if (over_range)
            begin
                code_reg <= CODE_MAX;
            end
            else if (under_range)
            begin
                code_reg <= CODE_MIN;
            end
            else
            begin
                // Flip MSB: offset binary to two's complement, this sample
                code_reg <= trial_reg ^ CODE_MIN;
            end
        end
    end

    assign result.code = code_reg;
    assign result.chain_mode = chain_reg;
    assign busy = !is_idle(state_reg);
    assign done_pulse = done_reg;

    // ************************************************************
    // Front-end switch control
    // ************************************************************
    always_comb
    begin
        // Ground switches closed only while acquiring; inputs attached while acquiring and in open-ground
        front_ctrl.pos_array_ground_switch = is_idle(state_reg);
        front_ctrl.neg_array_ground_switch = is_idle(state_reg);
        front_ctrl.inputs_attached = is_idle(state_reg)
                                     || (state_reg == ST_OPEN_GROUND);
        front_ctrl.arrays_grounded = (state_reg == ST_HOLD) || (state_reg == ST_TRIAL);
        // Analog core is off in acquisition, saving power at low rates
        front_ctrl.powered = !is_idle(state_reg);
    end

endmodule

// ---- verification/sar_front_end_model.sv ----
/* Behavioural analog front end: comparator and range flags.
   Assumes the bench sets the held sample and the range condition. */
`timescale 1ns/100ps
module sar_front_end_model
(
    // Sequencer side
    input wire logic [15:0] dac_pos,
    output logic comparator,
    output logic over_range,
    output logic under_range,
    // Bench side
    input wire logic [15:0] held_sample,
    input wire logic [1:0] range_sel
);
    // Trial word is offset binary, the sample two's complement
    assign comparator = $signed(dac_pos ^ 16'h8000) <= $signed(held_sample);
    assign over_range = range_sel[1];
    assign under_range = range_sel[0];
endmodule

// ---- verification/sar_seq_checker.sv ----
/* Port checker for the conversion sequencer.
   Assumes the bind below reaches every sequencer instance. */
`timescale 1ns/100ps
module sar_seq_checker
#(
    parameter int WIDTH = 16
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Host side
    input wire logic convert_strobe,
    input wire logic mode_select,
    // Front end
    input wire logic comparator,
    input wire logic over_range,
    input wire logic under_range,
    input sar_seq_pkg::front_ctrl_s front_ctrl,
    input wire logic [WIDTH-1:0] dac_pos,
    input wire logic [WIDTH-1:0] dac_neg,
    // Result
    input sar_seq_pkg::result_s result,
    input wire logic busy,
    input wire logic done_pulse
);
    import sar_seq_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    logic strobe_d;
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            strobe_d <= 1'b0;
        else
            strobe_d <= convert_strobe;
    end
    sequence start_s;
        convert_strobe && !strobe_d && !busy;
    endsequence
    sequence open_s;
        !front_ctrl.pos_array_ground_switch && !front_ctrl.neg_array_ground_switch
            && front_ctrl.inputs_attached;
    endsequence
    sequence hold_s;
        !front_ctrl.inputs_attached && front_ctrl.arrays_grounded;
    endsequence
    sequence done_low_s;
        done_pulse && $past(under_range && !over_range);
    endsequence
    done_time_a: assert property (start_s |->
        ##37 (busy && !done_pulse) ##1 (done_pulse && !busy))
        else $error("completion not 38 cycles after start");
    power_up_a: assert property (start_s |=> busy && front_ctrl.powered)
        else $error("start edge not taken");
    switch_order_a: assert property (start_s |=> open_s[*2] ##1 hold_s)
        else $error("switch order wrong");
    msb_first_a: assert property (start_s |-> ##5 dac_pos == 16'h8000)
        else $error("first trial not msb");
    keep_bit_a: assert property (start_s |->
        ##7 dac_pos[14] && dac_pos[15] == $past(comparator))
        else $error("msb decision wrong");
    dac_pair_a: assert property (dac_neg == ~dac_pos)
        else $error("arrays do not match");
    pulse_one_a: assert property (done_pulse |=> !done_pulse)
        else $error("done pulse too long");
    code_hold_a: assert property ($changed(result.code) |-> done_pulse)
        else $error("result changed without completion");
    power_down_a: assert property (front_ctrl.powered |-> busy)
        else $error("powered while idle");
    clamp_hi_a: assert property (done_pulse && $past(over_range) |->
        result.code == CODE_MAX)
        else $error("overrange not clamped");
    clamp_lo_a: assert property (done_low_s |-> result.code == CODE_MIN)
        else $error("underrange not clamped");
    mode_cap_a: assert property (start_s |=>
        result.chain_mode == !$past(mode_select))
        else $error("interface mode not latched at start");
endmodule

bind sar_conversion_sequencer sar_seq_checker #(.WIDTH(WIDTH)) chk (.sys_clk(sys_clk),
    .rstn(rstn), .convert_strobe(convert_strobe), .mode_select(mode_select),
    .comparator(comparator), .over_range(over_range), .under_range(under_range),
    .front_ctrl(front_ctrl), .dac_pos(dac_pos), .dac_neg(dac_neg), .result(result),
    .busy(busy), .done_pulse(done_pulse));

// ---- verification/tb_sar_conversion_sequencer.sv ----
/* Self-checking bench for the conversion sequencer.
   Assumes the behavioural front end model stands on the analog side. */
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
    $display("ERROR %s exp %h got %h", nm, ex, got); end end
module tb_sar_conversion_sequencer;
    import sar_seq_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic convert_strobe = 1'b0;
    logic mode_select = 1'b0;
    logic [15:0] held_sample = 16'h0000;
    logic [1:0] range_sel = 2'b00;
    logic comparator, over_range, under_range, busy, done_pulse;
    logic [15:0] dac_pos, dac_neg;
    front_ctrl_s front_ctrl;
    result_s result;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    always #25 sys_clk = ~sys_clk;
    sar_conversion_sequencer dut (.sys_clk(sys_clk), .rstn(rstn),
        .convert_strobe(convert_strobe), .mode_select(mode_select), .comparator(comparator),
        .over_range(over_range), .under_range(under_range), .front_ctrl(front_ctrl),
        .dac_pos(dac_pos), .dac_neg(dac_neg), .result(result), .busy(busy),
        .done_pulse(done_pulse));
    sar_front_end_model fe (.dac_pos(dac_pos), .comparator(comparator),
        .over_range(over_range), .under_range(under_range), .held_sample(held_sample),
        .range_sel(range_sel));
    task automatic report_and_stop();
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Whole run needs about 540 cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            report_and_stop();
        end
    end
    // One conversion; mode flips after start, tog wiggles strobe while busy
    task automatic conv(input logic [15:0] s, input logic m, input logic [1:0] r,
        input logic tog, input logic [15:0] ex);
        int n;
        @(posedge sys_clk);
        convert_strobe <= 1'b1;
        mode_select <= m;
        held_sample <= s;
        range_sel <= r;
        @(posedge sys_clk);
        mode_select <= ~m;
        convert_strobe <= tog;
        for (n = 1; n < 60; n++)
        begin
            @(negedge sys_clk);
            if (done_pulse === 1'b1)
                break;
            @(posedge sys_clk);
            if (tog)
                convert_strobe <= n[1];
        end
        `CHECK("latency", 38, n)
        `CHECK("code", ex, result.code)
        `CHECK("chain", ~m, result.chain_mode)
        `CHECK("busy", 1'b0, busy)
        `CHECK("attached", 1'b1, front_ctrl.inputs_attached)
        `CHECK("powered", 1'b0, front_ctrl.powered)
        @(posedge sys_clk);
        convert_strobe <= 1'b0;
    endtask
    task automatic test_reset();
        @(negedge sys_clk);
        `CHECK("rst code", CODE_RESET, result.code)
        `CHECK("rst dac", 16'hFFFF, dac_neg)
        `CHECK("rst busy", 1'b0, busy)
    endtask
    task automatic test_codes();
        logic [15:0] tbl [7] = '{16'h0000, 16'h0001, 16'hFFFF, 16'h7FFF, 16'h8000,
            16'h8001, 16'h1234};
        foreach (tbl[i])
            conv(tbl[i], i[0], 2'b00, 1'b0, tbl[i]);
    endtask
    task automatic test_clamps();
        conv(16'h0000, 1'b1, 2'b10, 1'b0, CODE_MAX);
        conv(16'h0000, 1'b0, 2'b01, 1'b0, CODE_MIN);
        conv(16'h8000, 1'b1, 2'b11, 1'b0, CODE_MAX);
    endtask
    task automatic test_restart();
        conv(16'h5A5A, 1'b1, 2'b00, 1'b1, 16'h5A5A);
        conv(16'hA5A5, 1'b0, 2'b00, 1'b1, 16'hA5A5);
    endtask
    // Reset in mid-conversion, then a clean conversion after release
    task automatic test_midrun_reset();
        @(posedge sys_clk);
        convert_strobe <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b0;
        convert_strobe <= 1'b0;
        @(negedge sys_clk);
        `CHECK("mid rst busy", 1'b0, busy)
        `CHECK("mid rst code", CODE_RESET, result.code)
        `CHECK("mid rst powered", 1'b0, front_ctrl.powered)
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        conv(16'h0123, 1'b1, 2'b00, 1'b0, 16'h0123);
    endtask
    initial
    begin
        repeat (5) @(posedge sys_clk);
        test_reset();
        @(posedge sys_clk);
        rstn <= 1'b1;
        test_codes();
        test_clamps();
        test_restart();
        test_midrun_reset();
        report_and_stop();
    end
endmodule
